// ---- inc/fqr_map.vh ----
`ifndef FQR_MAP_VH
`define FQR_MAP_VH
// Command codes and unlock addresses (word mode)
`define FQR_UNLOCK1_ADDR   22'h000555
`define FQR_UNLOCK2_ADDR   22'h0002aa
`define FQR_UNLOCK1_DATA   16'h00aa
`define FQR_UNLOCK2_DATA   16'h0055
`define FQR_QUERY_ADDR     22'h000055
`define FQR_QUERY_DATA     16'h0098
`define FQR_RESET_DATA     16'h00f0
`define FQR_PROG_DATA      16'h00a0
`define FQR_ERASE_SET_DATA 16'h0080
`define FQR_BLK_ERASE_DATA 16'h0030
`define FQR_SUSPEND_DATA   16'h00b0
`define FQR_RESUME_DATA    16'h0030
// Query table offsets and expected values
`define FQR_Q_SIG0         22'h000010
`define FQR_Q_SIG0_VAL     16'h0051
`define FQR_Q_EXT_PTR      22'h000015
`define FQR_Q_WRITE_TMO    22'h00001f
`define FQR_Q_DEV_SIZE     22'h000027
`define FQR_Q_DEV_SIZE_VAL 16'h0017
`define FQR_Q_REGIONS      22'h00002c
`define FQR_Q_SUSPEND      22'h000046
`define FQR_Q_SUSPEND_VAL  16'h0002
`define FQR_Q_SIMUL        22'h00004a
`define FQR_Q_BOOT_FLAG    22'h00004f
// Status word bit positions
`define FQR_POLL_BIT       7
`define FQR_TOGGLE1_BIT    6
`define FQR_TIMEOUT_BIT    5
`define FQR_RSVD_MID_BIT   4
`define FQR_WINDOW_BIT     3
`define FQR_TOGGLE2_BIT    2
// Avalon register offsets (word index)
`define FQR_REG_CTRL       3'h0
`define FQR_REG_ADDR       3'h1
`define FQR_REG_WDATA      3'h2
`define FQR_REG_STATUS     3'h3
`define FQR_REG_RDATA      3'h4
`define FQR_REG_LASTSTAT   3'h5
// Control opcodes
`define FQR_OP_READ        3'h0
`define FQR_OP_QUERY       3'h1
`define FQR_OP_EXIT        3'h2
`define FQR_OP_PROG        3'h3
`define FQR_OP_ERASE       3'h4
`define FQR_OP_SUSPEND     3'h5
`define FQR_OP_RESUME      3'h6
`define FQR_OP_POLLREAD    3'h7
// Bus cycle phase length minus one, in ref_clk cycles
`define FQR_PHASE_CYC      4'h3
`endif

// ---- verilog/fqr_bus_cycle.v ----
`timescale 1ns/1ps
// One asynchronous bus cycle on the flash pins, paced by ref_clk
module fqr_bus_cycle #(
    parameter AW = 22,
    parameter DW = 16
) (
    // Clock and reset
    input  wire          ref_clk,
    input  wire          rst,
    // Request
    input  wire          start,
    input  wire          isWrite,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output wire          busy,
    output reg           done_q,
    output reg  [DW-1:0] rdata_q,
    // Flash pins
    output reg  [AW-1:0] flashAddr_q,
    input  wire [DW-1:0] flashDqIn,
    output reg  [DW-1:0] flashDqOut_q,
    output reg           flashDqOe_q,
    output reg           flashCeN_q,
    output reg           flashOeN_q,
    output reg           flashWeN_q
);
`include "fqr_map.vh"
    localparam S_IDLE  = 2'd0;
    localparam S_SETUP = 2'd1;
    localparam S_PULSE = 2'd2;
    localparam S_HOLD  = 2'd3;
    reg [1:0] state_q;
    reg [3:0] cnt_q;
    reg       wr_q;
    assign busy = (state_q != S_IDLE);
    always @(posedge ref_clk) begin
        if (rst) begin
            state_q      <= S_IDLE;
            cnt_q        <= 4'h0;
            wr_q         <= 1'b0;
            done_q       <= 1'b0;
            rdata_q      <= {DW{1'b0}};
            flashAddr_q  <= {AW{1'b0}};
            flashDqOut_q <= {DW{1'b0}};
            flashDqOe_q  <= 1'b0;
            flashCeN_q   <= 1'b1;
            flashOeN_q   <= 1'b1;
            flashWeN_q   <= 1'b1;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        flashAddr_q  <= addr;
                        flashDqOut_q <= wdata;
                        flashDqOe_q  <= isWrite;
                        wr_q         <= isWrite;
                        flashCeN_q   <= 1'b0;
                        cnt_q        <= `FQR_PHASE_CYC;
                        state_q      <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_q == 4'h0) begin
                        flashWeN_q <= ~wr_q;
                        flashOeN_q <= wr_q;
                        cnt_q      <= `FQR_PHASE_CYC;
                        state_q    <= S_PULSE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                S_PULSE: begin
                    if (cnt_q == 4'h0) begin
                        // Sample before OE rises; each read is one OE access
                        rdata_q    <= flashDqIn;
                        flashWeN_q <= 1'b1;
                        flashOeN_q <= 1'b1;
                        cnt_q      <= `FQR_PHASE_CYC;
                        state_q    <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                S_HOLD: begin
                    if (cnt_q == 4'h0) begin
                        flashCeN_q  <= 1'b1;
                        flashDqOe_q <= 1'b0;
                        done_q      <= 1'b1;
                        state_q     <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule // fqr_bus_cycle

// ---- verilog/fqr_host.v ----
`timescale 1ns/1ps
module fqr_host #(
    parameter AW = 22,
    parameter DW = 16,
    parameter CLK_MHZ = 25,
    parameter WINDOW_US = 50
) (
    // Clock and reset
    input  wire          ref_clk,
    input  wire          rst,
    // Avalon-MM slave
    input  wire [2:0]    avsAddress,
    input  wire          avsRead,
    input  wire          avsWrite,
    input  wire [31:0]   avsWritedata,
    output reg  [31:0]   avsReaddata,
    output wire          avsWaitrequest,
    // Flash pins
    output wire [AW-1:0] flashAddr,
    input  wire [DW-1:0] flashDqIn,
    output wire [DW-1:0] flashDqOut,
    output wire          flashDqOe,
    output wire          flashCeN,
    output wire          flashOeN,
    output wire          flashWeN,
    input  wire          readyBusyN
);
`include "fqr_map.vh"
    localparam [31:0] WINDOW_FULL = WINDOW_US * CLK_MHZ;
    localparam [15:0] WINDOW_CYC = WINDOW_FULL[15:0];
    localparam H_IDLE = 3'd0;
    localparam H_SEQ  = 3'd1;
    localparam H_POLL = 3'd2;
    localparam H_PCHK = 3'd3;
    localparam H_SREAD = 3'd4;

    reg [2:0]    hstate_q;
    reg [2:0]    op_q;
    reg [2:0]    step_q;
    reg [2:0]    nSteps_q;
    reg [AW-1:0] addr_q;
    reg [15:0]   wdata_q;
    reg [15:0]   rdata_q;
    reg [15:0]   prevStat_q;
    reg          inQuery_q;
    reg          erasing_q;
    reg          suspended_q;
    reg          failed_q;
    reg          opDone_q;
    reg          refused_q;
    reg          rdPend_q;
    reg [15:0]   winCnt_q;
    reg          cycStart;
    reg          cycWr;
    reg [AW-1:0] cycAddr;
    reg [15:0]   cycData;
    wire         cycBusy;
    wire         cycDone;
    wire [15:0]  cycRdata;
    wire         hostBusy = (hstate_q != H_IDLE);
    wire         hostFree = !hostBusy;
    wire         ctrlWr = avsWrite && (avsAddress == `FQR_REG_CTRL);

    // Reserved bits masked; only meaningful flag bits kept
    function [15:0] stat_clean;
        input [15:0] s;
        begin
            stat_clean = s & 16'h00ec;
        end
    endfunction

    // Command sequence per step: address and data
    function [AW+15:0] seq_word;
        input [2:0] op;
        input [2:0] st;
        input [AW-1:0] a;
        input [15:0] d;
        begin
            seq_word = {`FQR_UNLOCK1_ADDR, `FQR_RESET_DATA};
            case (op)
                `FQR_OP_QUERY:
                    seq_word = {`FQR_QUERY_ADDR, `FQR_QUERY_DATA};
                `FQR_OP_EXIT:
                    seq_word = {`FQR_UNLOCK1_ADDR, `FQR_RESET_DATA};
                `FQR_OP_SUSPEND:
                    seq_word = {a, `FQR_SUSPEND_DATA};
                `FQR_OP_RESUME:
                    seq_word = {a, `FQR_RESUME_DATA};
                `FQR_OP_READ, `FQR_OP_POLLREAD:
                    seq_word = {a, d};
                `FQR_OP_PROG: begin
                    case (st)
                        3'd0: seq_word = {`FQR_UNLOCK1_ADDR, `FQR_UNLOCK1_DATA};
                        3'd1: seq_word = {`FQR_UNLOCK2_ADDR, `FQR_UNLOCK2_DATA};
                        3'd2: seq_word = {`FQR_UNLOCK1_ADDR, `FQR_PROG_DATA};
                        default: seq_word = {a, d};
                    endcase
                end
                `FQR_OP_ERASE: begin
                    case (st)
                        3'd0, 3'd3:
                            seq_word = {`FQR_UNLOCK1_ADDR, `FQR_UNLOCK1_DATA};
                        3'd1, 3'd4:
                            seq_word = {`FQR_UNLOCK2_ADDR, `FQR_UNLOCK2_DATA};
                        3'd2:
                            seq_word = {`FQR_UNLOCK1_ADDR, `FQR_ERASE_SET_DATA};
                        default: seq_word = {a, `FQR_BLK_ERASE_DATA};
                    endcase
                end
                default: seq_word = {`FQR_UNLOCK1_ADDR, `FQR_RESET_DATA};
            endcase
        end
    endfunction

    function [2:0] seq_len;
        input [2:0] op;
        begin
            case (op)
                `FQR_OP_PROG:  seq_len = 3'd4;
                `FQR_OP_ERASE: seq_len = 3'd6;
                default:       seq_len = 3'd1;
            endcase
        end
    endfunction

    // Extra erase commands only while window runs or erase is suspended; suspend, poll-read and exit allowed throughout
    wire eraseAllowed = !erasing_q || (winCnt_q != 16'h0000);
    wire cmdRefuse = erasing_q && !suspended_q
        && (avsWritedata[2:0] != `FQR_OP_SUSPEND)
        && (avsWritedata[2:0] != `FQR_OP_POLLREAD)
        && !((avsWritedata[2:0] == `FQR_OP_ERASE) && eraseAllowed)
        && (avsWritedata[2:0] != `FQR_OP_EXIT);

    // One wait state on reads so registered data stands at the accept edge
    assign avsWaitrequest = avsRead && !rdPend_q;

    always @* begin
        cycStart = (hstate_q == H_SEQ || hstate_q == H_POLL
                    || hstate_q == H_SREAD) && !cycBusy && !cycDone;
        cycWr    = (hstate_q == H_SEQ) && (op_q != `FQR_OP_READ)
                   && (op_q != `FQR_OP_POLLREAD);
        {cycAddr, cycData} = seq_word(op_q, step_q, addr_q, wdata_q);
        if (hstate_q != H_SEQ) begin
            cycAddr = addr_q;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            avsReaddata <= 32'h0000_0000;
            rdPend_q    <= 1'b0;
        end else begin
            rdPend_q <= avsRead && !rdPend_q;
            case (avsAddress)
                `FQR_REG_CTRL:   avsReaddata <= {29'h0, op_q};
                `FQR_REG_ADDR:   avsReaddata <= {{(32-AW){1'b0}}, addr_q};
                `FQR_REG_WDATA:  avsReaddata <= {16'h0, wdata_q};
                `FQR_REG_STATUS: avsReaddata <= {23'h0, refused_q,
                    readyBusyN, failed_q, opDone_q, suspended_q,
                    erasing_q, inQuery_q, hostBusy};
                `FQR_REG_RDATA:  avsReaddata <= {16'h0, rdata_q};
                `FQR_REG_LASTSTAT: avsReaddata <= {16'h0, prevStat_q};
                default:         avsReaddata <= 32'h0000_0000;
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            hstate_q <= H_IDLE;
            op_q <= `FQR_OP_READ;
            step_q <= 3'd0;
            nSteps_q <= 3'd1;
            addr_q <= {AW{1'b0}};
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            prevStat_q <= 16'h0000;
            inQuery_q <= 1'b0;
            erasing_q <= 1'b0;
            suspended_q <= 1'b0;
            failed_q <= 1'b0;
            opDone_q <= 1'b0;
            refused_q <= 1'b0;
            winCnt_q <= 16'h0000;
        end else begin
            if (winCnt_q != 16'h0000) begin
                winCnt_q <= winCnt_q - 16'h0001;
            end
            if (avsWrite && hostFree && avsAddress == `FQR_REG_ADDR) begin
                addr_q <= avsWritedata[AW-1:0];
            end
            if (avsWrite && hostFree && avsAddress == `FQR_REG_WDATA) begin
                wdata_q <= avsWritedata[15:0];
            end
            if (ctrlWr && hostFree) begin
                if (cmdRefuse) begin
                    refused_q <= 1'b1;
                end else begin
                    refused_q <= 1'b0;
                    op_q <= avsWritedata[2:0];
                    step_q <= (avsWritedata[2:0] == `FQR_OP_ERASE
                               && erasing_q) ? 3'd5 : 3'd0;
                    nSteps_q <= seq_len(avsWritedata[2:0]);
                    opDone_q <= 1'b0;
                    hstate_q <= H_SEQ;
                end
            end
            case (hstate_q)
                H_IDLE: begin
                end
                H_SEQ: begin
                    if (cycDone) begin
                        if (step_q + 3'd1 < nSteps_q) begin
                            step_q <= step_q + 3'd1;
                        end else begin
                            case (op_q)
                                `FQR_OP_QUERY: inQuery_q <= 1'b1;
                                `FQR_OP_EXIT: begin
                                    inQuery_q <= 1'b0;
                                    erasing_q <= 1'b0;
                                    suspended_q <= 1'b0;
                                    failed_q <= 1'b0;
                                end
                                `FQR_OP_SUSPEND: suspended_q <= erasing_q;
                                `FQR_OP_RESUME: suspended_q <= 1'b0;
                                `FQR_OP_ERASE: begin
                                    erasing_q <= 1'b1;
                                    winCnt_q <= WINDOW_CYC;
                                end
                                default: begin
                                end
                            endcase
                            if (op_q == `FQR_OP_READ) begin
                                // Upper byte zero in query mode
                                rdata_q <= inQuery_q ?
                                    {8'h00, cycRdata[7:0]} : cycRdata;
                                opDone_q <= 1'b1;
                                hstate_q <= H_IDLE;
                            end else if (op_q == `FQR_OP_ERASE) begin
                                // Host stays free so the window can be used
                                hstate_q <= H_IDLE;
                            end else if (op_q == `FQR_OP_PROG
                                         || op_q == `FQR_OP_POLLREAD) begin
                                // First status read follows last sequence cycle: the WE rise for program, a read for poll-read
                                hstate_q <= H_POLL;
                            end else begin
                                opDone_q <= 1'b1;
                                hstate_q <= H_IDLE;
                            end
                        end
                    end
                end
                H_POLL: begin
                    if (cycDone) begin
                        prevStat_q <= stat_clean(cycRdata);
                        hstate_q <= H_SREAD;
                    end
                end
                H_SREAD: begin
                    if (cycDone) begin
                        rdata_q <= cycRdata;
                        hstate_q <= H_PCHK;
                    end
                end
                H_PCHK: begin
                    // Older word kept until compared, then replaced
                    prevStat_q <= stat_clean(rdata_q);
                    // Toggle one steady across two reads means not busy
                    if (rdata_q[`FQR_TOGGLE1_BIT]
                        == prevStat_q[`FQR_TOGGLE1_BIT]
                        && (op_q != `FQR_OP_PROG
                            || rdata_q == wdata_q)) begin
                        opDone_q <= 1'b1;
                        if (!suspended_q) begin
                            erasing_q <= 1'b0;
                        end
                        hstate_q <= H_IDLE;
                    end else if (rdata_q[`FQR_TIMEOUT_BIT]) begin
                        failed_q <= 1'b1;
                        hstate_q <= H_IDLE;
                    end else if (op_q == `FQR_OP_POLLREAD) begin
                        hstate_q <= H_IDLE;
                    end else begin
                        hstate_q <= H_SREAD;
                    end
                end
                default: hstate_q <= H_IDLE;
            endcase
        end
    end

    fqr_bus_cycle #(
        .AW (AW),
        .DW (DW)
    ) uCycle (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .start        (cycStart),
        .isWrite      (cycWr),
        .addr         (cycAddr),
        .wdata        (cycData),
        .busy         (cycBusy),
        .done_q       (cycDone),
        .rdata_q      (cycRdata),
        .flashAddr_q  (flashAddr),
        .flashDqIn    (flashDqIn),
        .flashDqOut_q (flashDqOut),
        .flashDqOe_q  (flashDqOe),
        .flashCeN_q   (flashCeN),
        .flashOeN_q   (flashOeN),
        .flashWeN_q   (flashWeN)
    );
endmodule // fqr_host

// ---- verif/fqr_host_props.sv ----
`timescale 1ns/1ps
// Pin timing and reset checks on the flash host
module fqr_host_props #(
    parameter AW = 22,
    parameter DW = 16
) (
    // Clock and reset
    input wire          ref_clk,
    input wire          rst,
    // Avalon side
    input wire [2:0]    avsAddress,
    input wire          avsRead,
    input wire          avsWrite,
    input wire [31:0]   avsWritedata,
    input wire [31:0]   avsReaddata,
    input wire          avsWaitrequest,
    // Flash pins
    input wire [AW-1:0] flashAddr,
    input wire [DW-1:0] flashDqIn,
    input wire [DW-1:0] flashDqOut,
    input wire          flashDqOe,
    input wire          flashCeN,
    input wire          flashOeN,
    input wire          flashWeN,
    input wire          readyBusyN
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Strobe pulses: three or four cycles low, never longer
    sequence s_weLow;
        !flashWeN[*3] ##[1:2] flashWeN;
    endsequence
    sequence s_oeLow;
        !flashOeN[*3] ##[1:2] flashOeN;
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) rst |=> flashCeN
        && flashOeN && flashWeN && !flashDqOe && avsReaddata == 32'h0)
        else $error("pins not idle after reset");
    a_wait_low: assert property (avsWrite |-> !avsWaitrequest)
        else $error("waitrequest raised on write");
    a_read_wait: assert property (avsRead && avsWaitrequest |=>
        !avsWaitrequest) else $error("read wait longer than one cycle");
    a_strobe_excl: assert property (flashOeN || flashWeN)
        else $error("read and write strobes together");
    a_read_ce: assert property (!flashOeN |-> !flashCeN && !flashDqOe)
        else $error("read strobe without chip enable or with bus driven");
    a_write_ce: assert property (!flashWeN |-> !flashCeN && flashDqOe)
        else $error("write strobe without chip enable or data");
    a_we_pulse: assert property ($fell(flashWeN) |-> s_weLow)
        else $error("write pulse length wrong");
    a_oe_pulse: assert property ($fell(flashOeN) |-> s_oeLow)
        else $error("read pulse length wrong");
    a_ce_setup: assert property ($fell(flashCeN) |->
        (flashWeN && flashOeN)[*2]) else $error("strobe before setup");
    a_write_hold: assert property ($fell(flashWeN) |->
        ($stable(flashAddr) && $stable(flashDqOut))[*3])
        else $error("address or data moved under write");
endmodule // fqr_host_props

// ---- verif/fqr_flash_model.sv ----
`timescale 1ns/1ps
// Flash stand-in: query table, status word, wired ready/busy
module fqr_flash_model #(
    parameter BOOT   = 3,
    parameter WIN_NS = 2000
) (
    // Pins
    input  wire [21:0] addr,
    input  wire [15:0] dqHost,
    input  wire        ceN,
    input  wire        oeN,
    input  wire        weN,
    output wire [15:0] dqDev,
    output wire        readyBusyN
);
    reg [15:0] mem [0:255];
    reg [15:0] val, prev, pd;
    reg [7:0]  pa;
    reg        qry, busy, ers, fail, tog, drv, arm;
    integer    left, i;
    time       winEnd;
    initial begin
        for (i = 0; i < 256; i = i + 1) mem[i] = 16'hffff;
        {val, prev, pd, pa} = 0;
        {qry, busy, ers, fail, tog, drv, arm} = 0;
        left = 0;
        winEnd = 0;
    end
    function [15:0] cfi(input [6:0] a);
        case (a)
            7'h10: cfi = 16'h0051;
            7'h15: cfi = 16'h0040;
            7'h1f, 7'h25: cfi = 16'h0004;
            7'h21: cfi = 16'h000a;
            7'h23: cfi = 16'h0005;
            7'h27: cfi = 16'h0017;
            7'h28, 7'h2c, 7'h46: cfi = 16'h0002;
            7'h2d: cfi = 16'h0007;
            7'h2f: cfi = 16'h0020;
            7'h31: cfi = 16'h007e;
            7'h34, 7'h4a, 7'h50: cfi = 16'h0001;
            7'h4f: cfi = BOOT;
            default: cfi = 16'h0000;
        endcase
    endfunction
    // Commands land on the write strobe rise
    always @(posedge weN) if (!ceN) begin
        if (dqHost == 16'h00f0) begin
            qry = 0;
            busy = 0;
            fail = 0;
        end else if (busy) begin
            if (ers && dqHost == 16'h0030 && $time < winEnd)
                winEnd = $time + WIN_NS;
        end else if (dqHost == 16'h0098 && addr == 22'h55) qry = 1;
        else if (prev == 16'h00a0) begin
            pa = addr[7:0];
            pd = dqHost;
            fail = |(dqHost & ~mem[addr[7:0]]);
            {busy, ers, left} = {2'b10, 32'd4};
        end else if (arm && dqHost == 16'h0030) begin
            {busy, ers, arm, left} = {3'b110, 32'd4};
            winEnd = $time + WIN_NS;
        end else if (dqHost == 16'h0080) arm = 1;
        prev = dqHost;
    end
    // Status while busy, table in query mode, array otherwise
    always @(negedge oeN) if (!ceN) begin
        drv = 1;
        if (busy) begin
            tog = ~tog;
            val = 16'h0000;
            val[6] = tog;
            val[5] = fail;
            val[3] = fail || (ers && $time >= winEnd);
            val[7] = fail ? pd[7] : !ers && !pd[7];
            val[2] = !ers || tog;
            if (!fail && (!ers || $time >= winEnd)) left = left - 1;
            if (left == 0) begin
                busy = 0;
                for (i = 0; i < 256; i = i + 1) if (ers || i == pa) mem[i] = ers ? 16'hffff : pd;
            end
        end else val = qry ? cfi(addr[6:0]) : mem[addr[7:0]];
    end
    // Released bus shows the inverse, so no stale value passes
    always @(posedge oeN) drv = 0;
    assign dqDev = drv ? val : ~val;
    assign readyBusyN = !busy;
endmodule // fqr_flash_model

// ---- verif/fqr_host_tb.sv ----
`timescale 1ns/1ps
`include "fqr_map.vh"
module fqr_host_tb;
    // Clock, reset and Avalon side
    reg         ref_clk = 0, rst = 1, avsRead = 0, avsWrite = 0;
    reg  [2:0]  avsAddress = 0;
    reg  [31:0] avsWritedata = 0, rd;
    wire [31:0] avsReaddata;
    wire        avsWaitrequest;
    // Flash pins
    wire [21:0] flashAddr;
    wire [15:0] flashDqIn, flashDqOut, devDq;
    wire        flashDqOe, flashCeN, flashOeN, flashWeN, readyBusyN;
    integer     n_mismatch = 0, checks_done = 0, k;
    localparam [111:0] QA = {8'h10, 8'h15, 8'h1f, 8'h21, 8'h23, 8'h27,
        8'h28, 8'h2c, 8'h2d, 8'h2f, 8'h31, 8'h46, 8'h4a, 8'h4f};
    localparam [111:0] QV = {8'h51, 8'h40, 8'h04, 8'h0a, 8'h05, 8'h17,
        8'h02, 8'h02, 8'h07, 8'h20, 8'h7e, 8'h02, 8'h01, 8'h03};
    assign flashDqIn = flashDqOe ? flashDqOut : devDq;
    fqr_host #(.WINDOW_US(2)) fqr_host_inst (.ref_clk, .rst, .avsAddress,
        .avsRead, .avsWrite, .avsWritedata, .avsReaddata, .avsWaitrequest,
        .flashAddr, .flashDqIn, .flashDqOut, .flashDqOe, .flashCeN,
        .flashOeN, .flashWeN, .readyBusyN);
    fqr_flash_model fqr_flash_model_inst (.addr(flashAddr),
        .dqHost(flashDqIn), .ceN(flashCeN), .oeN(flashOeN),
        .weN(flashWeN), .dqDev(devDq), .readyBusyN(readyBusyN));
    initial forever #20 ref_clk = ~ref_clk;
    task check(input [31:0] exp, input [31:0] got, input string what);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task avWr(input [2:0] a, input [31:0] d);
        @(posedge ref_clk);
        {avsAddress, avsWritedata, avsWrite} <= {a, d, 1'b1};
        @(posedge ref_clk);
        while (avsWaitrequest !== 1'b0) @(posedge ref_clk);
        avsWrite <= 0;
    endtask
    // Read data taken at the edge that sees waitrequest low
    task avRd(input [2:0] a);
        @(posedge ref_clk);
        {avsAddress, avsRead} <= {a, 1'b1};
        @(posedge ref_clk);
        while (avsWaitrequest !== 1'b0) @(posedge ref_clk);
        rd = avsReaddata;
        avsRead <= 0;
    endtask
    task waitIdle;
        rd = 1;
        for (k = 0; k < 3000 && rd[0] !== 1'b0; k = k + 1) avRd(`FQR_REG_STATUS);
    endtask
    task op(input [2:0] code, input [21:0] a, input [15:0] d);
        avWr(`FQR_REG_ADDR, {10'h000, a});
        avWr(`FQR_REG_WDATA, {16'h0000, d});
        avWr(`FQR_REG_CTRL, {29'h0, code});
        waitIdle;
    endtask
    task readAt(input [21:0] a);
        op(`FQR_OP_READ, a, 16'h0000);
        avRd(`FQR_REG_RDATA);
    endtask
    task t_idle;
        check(4'b1110, {flashCeN, flashOeN, flashWeN, flashDqOe}, "pins");
        avRd(`FQR_REG_STATUS);
        check(2'b10, {rd[6], rd[0]}, "ready");
    endtask
    task t_query;
        op(`FQR_OP_QUERY, 22'h55, `FQR_QUERY_DATA);
        for (int i = 0; i < 14; i++) begin
            readAt({14'h0, QA[8*(13-i)+:8]});
            check({24'h0, QV[8*(13-i)+:8]}, rd, "table");
        end
        op(`FQR_OP_EXIT, 22'h0, `FQR_RESET_DATA);
        readAt(22'h10);
        check(32'hffff, rd, "array after exit");
    endtask
    task t_program;
        op(`FQR_OP_PROG, 22'h20, 16'h1234);
        avRd(`FQR_REG_STATUS);
        check(3'b011, {rd[5:4], rd[6]}, "prog done");
        avRd(`FQR_REG_LASTSTAT);
        check(32'h0, rd & 32'h13, "reserved bits");
        readAt(22'h20);
        check(32'h1234, rd, "programmed word");
    endtask
    task t_fail;
        op(`FQR_OP_PROG, 22'h20, 16'h00ff);
        avRd(`FQR_REG_STATUS);
        check(2'b10, {rd[5], rd[6]}, "fail, busy pin");
        op(`FQR_OP_EXIT, 22'h0, `FQR_RESET_DATA);
        readAt(22'h20);
        check(32'h1234, rd, "word after fail");
    endtask
    task t_erase;
        avWr(`FQR_REG_ADDR, 32'h20);
        avWr(`FQR_REG_CTRL, {29'h0, `FQR_OP_ERASE});
        rd = 0;
        for (k = 0; k < 500 && rd[2] !== 1'b1; k = k + 1) avRd(`FQR_REG_STATUS);
        avWr(`FQR_REG_CTRL, {29'h0, `FQR_OP_ERASE});
        waitIdle;
        check(1'b0, rd[7], "append in window");
        avWr(`FQR_REG_CTRL, {29'h0, `FQR_OP_PROG});
        avRd(`FQR_REG_STATUS);
        check(1'b1, rd[7], "refused");
        for (int j = 0; j < 100 && rd[2] !== 1'b0; j++)
            op(`FQR_OP_POLLREAD, 22'h20, 16'h0000);
        check(1'b0, rd[2], "erase done");
        readAt(22'h20);
        check(32'hffff, rd, "erased word");
    endtask
    task test_done;
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #800000;
        n_mismatch = n_mismatch + 1;
        test_done;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 0;
        t_idle;
        t_query;
        t_program;
        t_fail;
        t_erase;
        test_done;
    end
endmodule // fqr_host_tb
bind fqr_host fqr_host_props #(.AW(AW), .DW(DW)) fqr_host_props_inst (
    .ref_clk, .rst, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsReaddata, .avsWaitrequest, .flashAddr, .flashDqIn, .flashDqOut,
    .flashDqOe, .flashCeN, .flashOeN, .flashWeN, .readyBusyN);
